// ### core/mbi_params.svh
// constants of the multiplexed bus interface unit
// assumes a single 125 MHz core clock and a synchronous reset
// Function
// RULE1: strobe marks valid address on shared bus
// RULE2: snoop DMA write address at master strobe
// RULE3: load strobe marks read transaction
// RULE4: store strobe out; DMA write marker in
// RULE5: drive permit only after bus released
// RULE6: drive permit low on writes and idle
// RULE7: memory drives bus only while permitted
// RULE8: block read asks four contiguous words
// RULE9: block read on icache, dcache quad misses
// RULE10: page hint on back-to-back same-page writes
// RULE11: transfer done ends write, delivers read
// RULE12: DMA transfer done bumps invalidation address
// RULE13: capture enable moves data into buffer
// RULE14: reference clock full or half, reset-chosen
// RULE15: hold request makes device float outputs
// RULE16: acknowledge hold after bus released
// RULE17: invalidate request kills matching cache line
// RULE18: DMA master flags coherent operations
// RULE19: branch inputs feed coprocessor conditions
// RULE20: synchronized branch inputs pass synchronizers
// RULE21: direct branch input arrives synchronous
// RULE22: fault sampled in transfers, ends them
// RULE23: faulted read raises bus error exception
// RULE24: word index counts up from zero
// RULE25: stay released until hold request drops
// RULE26: block read: four captures then done
`ifndef MBI_PARAMS_SVH
`define MBI_PARAMS_SVH
`define MBI_ALE_CYCLES 4'h2
`define MBI_TURN_CYCLES 4'h1
`define MBI_BURST_WORDS 4
`define MBI_PAGE_LSB 11
`define MBI_FIFO_DEPTH 8
`define MBI_DATA_W 32
`endif

// ### core/mbi_pkg.sv
// types shared by the bus interface unit
// assumes nothing of its surroundings
`default_nettype none
package mbi_pkg;
  typedef enum logic [2:0] {
    MBI_IDLE, MBI_ADDR, MBI_TURN, MBI_RDATA, MBI_WDATA,
    MBI_REL, MBI_HOLD
  } mbi_state_t;
  typedef enum logic [1:0] {
    MBI_UNCACHED, MBI_IMISS, MBI_DMISS
  } mbi_kind_t;
endpackage
`default_nettype wire

// ### core/mbi_bus_if.sv
// read buffer fifo and the bus interface unit top
// assumes core-side requests on i_clk; all bus pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "mbi_params.svh"

module mbi_fifo #(
  parameter int W = 32,
  parameter int D = 8,
  parameter int FW = $clog2(D + 1)
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic [FW-1:0] o_free
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [FW-1:0] cnt;
    logic vld;
    logic rdy;
  } mbi_fifo_st_t;
  mbi_fifo_st_t q, d;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  assign push = i_in_valid && q.rdy;
  assign pop = q.vld && i_out_ready;
  assign o_in_ready = q.rdy;
  assign o_out_valid = q.vld;
  assign o_out_data = mem[q.rp];
  assign o_free = FW'(D) - q.cnt;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + FW'(push) - FW'(pop);
    d.vld = d.cnt != '0;
    d.rdy = d.cnt != FW'(D);
    if (i_reset) begin
      d = '0;
      d.rdy = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
    if (push) begin
      mem[q.wp] <= i_in_data;
    end
  end
endmodule

module mbi_bus_if
  import mbi_pkg::*;
#(
  parameter int DEPTH = `MBI_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_half_rate_strap,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [1:0] i_req_kind,
  input wire logic i_quad_refill,
  input wire logic [31:0] i_req_addr,
  input wire logic [31:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [31:0] o_rd_data,
  output logic o_rd_done,
  output logic o_wr_done,
  output logic o_bus_error_exception,
  output logic o_write_fault,
  output logic o_invalidate_valid,
  output logic [29:0] o_invalidate_addr,
  input wire logic [1:0] i_synchronized_branch_condition,
  input wire logic i_direct_branch_condition,
  input wire logic i_floating_point_unit_condition,
  output logic [3:0] o_coprocessor_condition,
  output logic o_bus_reference_clock,
  input wire logic [31:0] i_ad,
  output logic [31:0] o_ad,
  output logic o_ad_oe,
  input wire logic i_ale,
  output logic o_ale,
  output logic o_ale_oe,
  output logic o_load_strobe,
  output logic o_load_strobe_oe,
  input wire logic i_store_strobe,
  output logic o_store_strobe,
  output logic o_store_strobe_oe,
  output logic [1:0] o_word_index,
  output logic o_word_index_oe,
  output logic o_block_read_or_near,
  output logic o_block_read_or_near_oe,
  output logic o_memory_drive_permit,
  input wire logic i_transfer_done,
  input wire logic i_read_buffer_capture_enable,
  input wire logic i_transfer_fault,
  input wire logic i_hold_request,
  output logic o_hold_acknowledge,
  input wire logic i_line_invalidate_request,
  input wire logic i_coherent_dma_request
);
  localparam int NS = 11;
  localparam int FW = $clog2(DEPTH + 1);
  localparam int S_DONE = 0;
  localparam int S_RCE = 1;
  localparam int S_HOLD = 2;
  localparam int S_INV = 3;
  localparam int S_COH = 4;
  localparam int S_FLT = 5;
  localparam int S_ALE = 6;
  localparam int S_STB = 7;
  localparam int S_SB0 = 8;
  localparam int S_SB1 = 9;
  localparam int S_STRAP = 10;

  typedef struct packed {
    mbi_state_t st;
    logic [3:0] cnt;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic burst;
    logic last_wr;
    logic [31:`MBI_PAGE_LSB] last_page;
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [31:0] ad1;
    logic [31:0] ad2;
    logic half;
    logic div;
    logic ref_clk;
    logic [31:0] ad_o;
    logic ad_oe;
    logic ctl_oe;
    logic ale;
    logic rd;
    logic stb;
    logic blk_near;
    logic [1:0] idx;
    logic permit;
    logic hold_ack;
    logic req_ready;
    logic rd_done;
    logic wr_done;
    logic rd_fault;
    logic wr_fault;
    logic inv_valid;
    logic [29:0] inv_addr;
    logic [3:0] cpc;
    logic push;
    logic [31:0] push_data;
  } mbi_st_t;

  mbi_st_t q, d;
  logic [NS-1:0] in_vec;
  logic [NS-1:0] rise;
  logic fifo_ready;
  logic [FW-1:0] fifo_free;
  logic free_ok;
  logic near;
  logic burst;

  assign in_vec = {i_half_rate_strap, i_synchronized_branch_condition,
                   i_store_strobe, i_ale, i_transfer_fault,
                   i_coherent_dma_request, i_line_invalidate_request,
                   i_hold_request, i_read_buffer_capture_enable,
                   i_transfer_done};
  assign rise = q.s2 & ~q.s3;
  // room for a whole block read, counting a push still in flight
  assign free_ok = fifo_ready &&
                   (fifo_free >= FW'(`MBI_BURST_WORDS) + FW'(q.push));
  assign near = q.last_wr &&
                (i_req_addr[31:`MBI_PAGE_LSB] == q.last_page);
  assign burst = (mbi_kind_t'(i_req_kind) == MBI_IMISS) ||
                 ((mbi_kind_t'(i_req_kind) == MBI_DMISS) && i_quad_refill);

  mbi_fifo #(.W(`MBI_DATA_W), .D(DEPTH)) u_rdbuf (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_in_valid(q.push),
    .o_in_ready(fifo_ready),
    .i_in_data(q.push_data),
    .o_out_valid(o_rd_valid),
    .i_out_ready(i_rd_ready),
    .o_out_data(o_rd_data),
    .o_free(fifo_free)
  );

  always_comb begin
    d = q;
    d.s1 = in_vec;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.ad1 = i_ad;
    d.ad2 = q.ad1;
    d.push = 1'b0;
    d.rd_done = 1'b0;
    d.wr_done = 1'b0;
    d.rd_fault = 1'b0;
    d.wr_fault = 1'b0;
    d.inv_valid = 1'b0;
    d.cpc = {q.s2[S_SB1], q.s2[S_SB0], i_floating_point_unit_condition,
             i_direct_branch_condition}; // [RULE19] [RULE20] [RULE21]
    // full rate toggles every cycle, half rate every second one
    d.div = q.half ? ~q.div : 1'b0;
    if (!q.half || q.div) begin
      d.ref_clk = ~q.ref_clk; // [RULE14]
    end
    case (q.st)
      MBI_IDLE: begin
        if (q.s2[S_HOLD]) begin
          d.st = MBI_REL;
          d.ctl_oe = 1'b0; // [RULE15]
          d.ad_oe = 1'b0;
          d.last_wr = 1'b0;
        end else if (i_req_valid && q.req_ready) begin
          d.st = MBI_ADDR;
          d.cnt = `MBI_ALE_CYCLES - 4'h1;
          d.addr = i_req_addr;
          d.wdata = i_req_wdata;
          d.wr = i_req_write;
          d.burst = burst && !i_req_write;
          d.ad_o = i_req_addr;
          d.ad_oe = 1'b1;
          d.ale = 1'b1; // [RULE1]
          d.rd = !i_req_write; // [RULE3]
          d.stb = i_req_write; // [RULE4]
          // [RULE8] [RULE9] [RULE10]
          d.blk_near = i_req_write ? near : burst;
          d.idx = (burst && !i_req_write) ? 2'h0 : i_req_addr[3:2];
        end
      end
      MBI_ADDR: begin
        if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else begin
          d.ale = 1'b0;
          if (q.wr) begin
            d.st = MBI_WDATA;
            d.ad_o = q.wdata;
          end else begin
            d.st = MBI_TURN;
            d.ad_oe = 1'b0;
            d.cnt = `MBI_TURN_CYCLES - 4'h1;
          end
        end
      end
      MBI_TURN: begin
        if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else begin
          d.st = MBI_RDATA;
          d.permit = 1'b1; // [RULE5]
        end
      end
      MBI_RDATA: begin
        if (rise[S_FLT]) begin
          d.rd_fault = 1'b1; // [RULE22] [RULE23]
          d.st = MBI_IDLE;
        end else begin
          if (rise[S_RCE]) begin
            d.push = 1'b1; // [RULE13] [RULE26]
            d.push_data = q.ad2;
            d.idx = q.idx + 2'h1; // [RULE24]
          end
          if (rise[S_DONE]) begin
            d.rd_done = 1'b1; // [RULE11]
            d.st = MBI_IDLE;
          end
        end
        if (d.st == MBI_IDLE) begin
          d.permit = 1'b0; // [RULE6]
          d.rd = 1'b0;
          d.blk_near = 1'b0;
          d.last_wr = 1'b0;
        end
      end
      MBI_WDATA: begin
        if (rise[S_FLT] || rise[S_DONE]) begin
          d.st = MBI_IDLE;
          d.wr_fault = rise[S_FLT]; // [RULE22]
          d.wr_done = !rise[S_FLT]; // [RULE11]
          d.ad_oe = 1'b0;
          d.stb = 1'b0;
          d.blk_near = 1'b0;
          d.last_wr = !rise[S_FLT];
          d.last_page = q.addr[31:`MBI_PAGE_LSB];
        end
      end
      MBI_REL: begin
        d.hold_ack = 1'b1; // [RULE16]
        d.st = MBI_HOLD;
      end
      MBI_HOLD: begin
        if (!q.s2[S_HOLD]) begin
          d.hold_ack = 1'b0; // [RULE25]
          d.ctl_oe = 1'b1;
          d.st = MBI_IDLE;
        end else if (q.s2[S_COH]) begin
          if (rise[S_ALE] && q.s2[S_STB]) begin
            d.inv_addr = q.ad2[31:2]; // [RULE2] [RULE4]
          end else if (rise[S_DONE]) begin
            d.inv_addr = q.inv_addr + 30'h1; // [RULE12]
          end
          d.inv_valid = rise[S_INV]; // [RULE17] [RULE18]
        end
      end
      default: begin
        d.st = MBI_IDLE;
      end
    endcase
    d.req_ready = (d.st == MBI_IDLE) && !q.s2[S_HOLD] && free_ok &&
                  !(q.st == MBI_IDLE && i_req_valid && q.req_ready);
    if (i_reset) begin
      d = '0;
      d.ctl_oe = 1'b1;
      d.s1 = in_vec;
      d.s2 = q.s1;
      d.half = q.s2[S_STRAP]; // [RULE14]
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  assign o_req_ready = q.req_ready;
  assign o_rd_done = q.rd_done;
  assign o_wr_done = q.wr_done;
  assign o_bus_error_exception = q.rd_fault;
  assign o_write_fault = q.wr_fault;
  assign o_invalidate_valid = q.inv_valid;
  assign o_invalidate_addr = q.inv_addr;
  assign o_coprocessor_condition = q.cpc;
  assign o_bus_reference_clock = q.ref_clk;
  assign o_ad = q.ad_o;
  assign o_ad_oe = q.ad_oe;
  assign o_ale = q.ale;
  assign o_ale_oe = q.ctl_oe;
  assign o_load_strobe = q.rd;
  assign o_load_strobe_oe = q.ctl_oe;
  assign o_store_strobe = q.stb;
  assign o_store_strobe_oe = q.ctl_oe;
  assign o_word_index = q.idx;
  assign o_word_index_oe = q.ctl_oe;
  assign o_block_read_or_near = q.blk_near;
  assign o_block_read_or_near_oe = q.ctl_oe;
  assign o_memory_drive_permit = q.permit;
  assign o_hold_acknowledge = q.hold_ack;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_permit_off_bus;
    q.permit |-> !q.ad_oe && q.rd;
  endproperty
  a_permit_off_bus: assert property (p_permit_off_bus) // [RULE5]
    else $error("drive permit while bus driven");

  property p_permit_write_idle;
    (q.st == MBI_WDATA || q.st == MBI_IDLE) |-> !q.permit;
  endproperty
  a_permit_write_idle: assert property (p_permit_write_idle) // [RULE6]
    else $error("drive permit during write or idle");

  property p_ale_addr;
    q.ale |-> q.ad_oe && q.ad_o == q.addr;
  endproperty
  a_ale_addr: assert property (p_ale_addr) // [RULE1]
    else $error("address strobe without address");

  property p_burst_start;
    $rose(q.rd) && q.blk_near |-> q.idx == 2'h0 && q.ale;
  endproperty
  a_burst_start: assert property (p_burst_start) // [RULE24]
    else $error("block read does not start at word zero");

  property p_index_step;
    q.st == MBI_RDATA && rise[S_RCE] && !rise[S_FLT]
      |=> q.push && q.push_data == $past(q.ad2)
          && q.idx == $past(q.idx) + 2'h1;
  endproperty
  a_index_step: assert property (p_index_step) // [RULE24]
    else $error("capture did not push or step index");

  property p_release_ack;
    q.st == MBI_REL |=> q.hold_ack && !q.ctl_oe && !q.ad_oe;
  endproperty
  a_release_ack: assert property (p_release_ack) // [RULE16]
    else $error("hold acknowledged with bus driven");

  property p_hold_stays;
    q.hold_ack && q.s2[S_HOLD] |=> q.hold_ack && !q.ctl_oe;
  endproperty
  a_hold_stays: assert property (p_hold_stays) // [RULE25]
    else $error("hold dropped while requested");

  property p_inv_count;
    q.st == MBI_HOLD && q.s2[S_HOLD] && q.s2[S_COH] && rise[S_DONE]
      && !rise[S_ALE] |=> q.inv_addr == $past(q.inv_addr) + 30'h1;
  endproperty
  a_inv_count: assert property (p_inv_count) // [RULE12]
    else $error("invalidation address not incremented");

  property p_read_fault;
    q.st == MBI_RDATA && rise[S_FLT]
      |=> q.rd_fault && q.st == MBI_IDLE ##1 !q.rd_fault;
  endproperty
  a_read_fault: assert property (p_read_fault) // [RULE23]
    else $error("faulted read without exception");

  property p_ref_full;
    !q.half && !$past(q.half) && !$past(i_reset)
      |-> q.ref_clk != $past(q.ref_clk);
  endproperty
  a_ref_full: assert property (p_ref_full) // [RULE14]
    else $error("reference clock not at full rate");

  c_burst_read: cover property (q.st == MBI_RDATA && q.burst ##1
                                q.rd_done);
  c_write: cover property (q.wr_done);
  c_hold: cover property (q.hold_ack ##1 q.inv_valid);
endmodule
`default_nettype wire

// ### verif/mbi_mem_model.sv
// memory model on the far side of the bus unit: answers reads and writes
// assumes the bench resolves the shared bus and feeds the pins back in
`timescale 1ns/1ps
`default_nettype none
module mbi_mem_model (
  input wire logic i_clk,
  input wire logic i_ale,
  input wire logic i_load,
  input wire logic i_store,
  input wire logic i_permit,
  input wire logic i_block,
  input wire logic i_fault,
  input wire logic [31:0] i_ad,
  output logic [31:0] o_data,
  output logic o_cen,
  output logic o_done,
  output logic o_err
);
  logic [31:0] a;
  logic b, drv;
  int n;
  initial begin
    {o_data, o_cen, o_done, o_err, a, b, drv} = 0;
  end
  // released bus alternates each cycle between the inverse of the last word and the last word
  always @(posedge i_clk) if (!drv) o_data <= ~o_data;
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  always begin
    step(1);
    if (i_ale) begin
      a = i_ad;
      b = i_block;
    end
    if (i_load && i_permit) begin
      if (i_fault) o_err = 1;
      else begin
        for (n = 0; n < (b ? 4 : 1) && i_permit; n++) begin
          drv = 1;
          o_data = a ^ 32'(n);
          step(1);
          o_cen = 1;
          step(2);
          o_cen = 0;
          step(1);
          drv = 0;
        end
        o_done = 1;
      end
      for (n = 0; n < 20 && i_load; n++) step(1);
      {o_done, o_err} = 0;
    end else if (i_store && !i_ale) begin
      step(4);
      if (i_fault) o_err = 1;
      else o_done = 1;
      for (n = 0; n < 20 && i_store; n++) step(1);
      {o_done, o_err} = 0;
    end
  end
endmodule
`default_nettype wire

// ### verif/test_mbi_bus_if.sv
// bench for the bus interface unit with a memory model on the far side
// assumes the design sources and mbi_mem_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_mbi_bus_if;
  logic i_clk, i_reset, i_half_rate_strap, i_req_valid, i_req_write;
  logic i_quad_refill, o_req_ready, o_rd_valid, i_rd_ready, o_rd_done;
  logic o_wr_done, o_bus_error_exception, o_write_fault, o_invalidate_valid;
  logic i_direct_branch_condition, i_floating_point_unit_condition;
  logic o_bus_reference_clock, o_ad_oe, i_ale, o_ale, o_ale_oe;
  logic o_load_strobe, o_load_strobe_oe, i_store_strobe, o_store_strobe;
  logic o_store_strobe_oe, o_word_index_oe, o_block_read_or_near;
  logic o_block_read_or_near_oe, o_memory_drive_permit, i_transfer_done;
  logic i_read_buffer_capture_enable, i_transfer_fault, i_hold_request;
  logic o_hold_acknowledge, i_line_invalidate_request, mem_done;
  logic i_coherent_dma_request, dma_on, dma_ale, dma_wr, dma_done, flt;
  logic [1:0] i_req_kind, i_synchronized_branch_condition, o_word_index;
  logic [3:0] o_coprocessor_condition, f;
  logic [2:0] bi;
  logic [29:0] o_invalidate_addr;
  logic [31:0] i_req_addr, i_req_wdata, o_rd_data, i_ad, o_ad, dma_ad, mem_ad;
  int errors, compares, n;
  assign i_ad = o_ad_oe ? o_ad : (dma_on ? dma_ad : mem_ad);
  assign i_ale = o_ale_oe ? o_ale : dma_ale;
  assign i_store_strobe = o_store_strobe_oe ? o_store_strobe : dma_wr;
  assign i_transfer_done = mem_done | dma_done;
  mbi_bus_if dut (.i_clk, .i_reset, .i_half_rate_strap, .i_req_valid,
    .i_req_write, .i_req_kind, .i_quad_refill, .i_req_addr, .i_req_wdata,
    .o_req_ready, .o_rd_valid, .i_rd_ready, .o_rd_data, .o_rd_done,
    .o_wr_done, .o_bus_error_exception, .o_write_fault, .o_invalidate_valid,
    .o_invalidate_addr, .i_synchronized_branch_condition,
    .i_direct_branch_condition, .i_floating_point_unit_condition,
    .o_coprocessor_condition, .o_bus_reference_clock, .i_ad, .o_ad,
    .o_ad_oe, .i_ale, .o_ale, .o_ale_oe, .o_load_strobe, .o_load_strobe_oe,
    .i_store_strobe, .o_store_strobe, .o_store_strobe_oe, .o_word_index,
    .o_word_index_oe, .o_block_read_or_near, .o_block_read_or_near_oe,
    .o_memory_drive_permit, .i_transfer_done, .i_read_buffer_capture_enable,
    .i_transfer_fault, .i_hold_request, .o_hold_acknowledge,
    .i_line_invalidate_request, .i_coherent_dma_request);
  mbi_mem_model mem (.i_clk, .i_ale(o_ale & o_ale_oe),
    .i_load(o_load_strobe), .i_store(o_store_strobe & o_store_strobe_oe),
    .i_permit(o_memory_drive_permit), .i_block(o_block_read_or_near),
    .i_fault(flt), .i_ad, .o_data(mem_ad),
    .o_cen(i_read_buffer_capture_enable), .o_done(mem_done),
    .o_err(i_transfer_fault));
  initial begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // permit may never overlap our own bus drive or a write
  always @(negedge i_clk) if (o_memory_drive_permit === 1'b1) begin
    chk("permit", {o_ad_oe, o_store_strobe}, 0);
  end
  task automatic req(input logic w, input logic [1:0] k,
      input logic [31:0] ad);
    logic [31:0] al;
    logic [1:0] ls;
    {al, bi, f, ls} = 0;
    {i_req_write, i_req_kind, i_req_addr, i_req_wdata} = {w, k, ad, ~ad};
    i_req_valid = 1;
    for (n = 0; n < 50 && o_req_ready !== 1; n++) @(negedge i_clk);
    @(negedge i_clk);
    i_req_valid = 0;
    for (n = 0; n < 300 && f == 0; n++) begin
      if (o_ale && o_ale_oe) begin
        al = o_ad;
        bi = {o_block_read_or_near, o_word_index};
        ls = {o_load_strobe, o_store_strobe};
      end
      f = {o_rd_done, o_wr_done, o_bus_error_exception, o_write_fault};
      @(negedge i_clk);
    end
    if (f == 0) begin
      errors++;
      end_sim();
    end
    chk("ale addr", al, ad);
    chk("strobes", ls, {~w, w});
  endtask
  task automatic pop(input int cnt, input logic [31:0] a);
    i_rd_ready = 1;
    for (int j = 0; j < cnt; j++) begin
      for (n = 0; n < 20 && o_rd_valid !== 1; n++) @(negedge i_clk);
      chk("valid", o_rd_valid, 1);
      chk("word", o_rd_data, a ^ 32'(j));
      @(negedge i_clk);
    end
    i_rd_ready = 0;
  endtask
  task automatic t_reads();
    logic [1:0] kd [4] = '{0, 1, 2, 2};
    for (int i = 0; i < 4; i++) begin
      i_quad_refill = i[1] & i[0];
      req(0, kd[i], 32'h400 + 32'(i) * 16);
      chk("rd flags", f, 4'h8);
      chk("block idx", bi, {i[0], 2'b00});
      pop(i[0] ? 4 : 1, 32'h400 + 32'(i) * 16);
    end
    req(0, 1, 32'h800);
    req(0, 1, 32'h900);
    repeat (4) @(negedge i_clk);
    chk("full refuse", o_req_ready, 0);
    pop(4, 32'h800);
    @(negedge i_clk);
    pop(4, 32'h900);
    chk("empty", o_rd_valid, 0);
    $display("t_reads done");
  endtask
  task automatic t_writes();
    logic [31:0] ad [3] = '{32'h1000, 32'h17fc, 32'h1808};
    logic [2:0] ex [3] = '{3'h0, 3'h7, 3'h2};
    for (int i = 0; i < 3; i++) begin
      req(1, 0, ad[i]);
      chk("wr flags", f, 4'h4);
      chk("near idx", bi, ex[i]);
    end
    flt = 1;
    req(0, 0, 32'h40);
    chk("rd fault", f, 4'h2);
    req(1, 0, 32'h44);
    chk("wr fault", f, 4'h1);
    flt = 0;
    $display("t_writes done");
  endtask
  task automatic t_hold();
    {i_hold_request, i_coherent_dma_request} = 2'b11;
    for (n = 0; n < 20 && o_hold_acknowledge !== 1; n++) @(negedge i_clk);
    chk("ack", o_hold_acknowledge, 1);
    chk("oe", {o_ad_oe, o_ale_oe, o_store_strobe_oe, o_load_strobe_oe,
        o_word_index_oe, o_block_read_or_near_oe}, 0);
    {dma_on, dma_ad, dma_wr, dma_ale} = {1'b1, 32'h2468, 2'b11};
    repeat (4) @(negedge i_clk);
    dma_ale = 0;
    repeat (2) begin
      dma_done = 1;
      repeat (4) @(negedge i_clk);
      dma_done = 0;
      repeat (4) @(negedge i_clk);
    end
    i_line_invalidate_request = 1;
    for (n = 0; n < 10 && o_invalidate_valid !== 1; n++) @(negedge i_clk);
    chk("inv valid", o_invalidate_valid, 1);
    chk("inv addr", o_invalidate_addr, 30'h91c);
    {i_line_invalidate_request, dma_wr, dma_on, i_hold_request} = 0;
    for (n = 0; n < 20 && o_hold_acknowledge !== 0; n++) @(negedge i_clk);
    chk("release", {o_hold_acknowledge, o_ale_oe}, 1);
    $display("t_hold done");
  endtask
  task automatic t_misc();
    logic p;
    int c;
    i_synchronized_branch_condition = 2'b10;
    i_direct_branch_condition = 1;
    repeat (5) @(negedge i_clk);
    chk("cond a", o_coprocessor_condition, 4'h9);
    {i_synchronized_branch_condition, i_direct_branch_condition} = 3'b010;
    i_floating_point_unit_condition = 1;
    repeat (5) @(negedge i_clk);
    chk("cond b", o_coprocessor_condition, 4'h6);
    // second pass: reset again mid-run with the half-rate strap high
    for (int h = 0; h < 2; h++) begin
      if (h == 1) begin
        {i_half_rate_strap, i_reset} = 2'b11;
        repeat (4) @(negedge i_clk);
        i_reset = 0;
        repeat (3) @(negedge i_clk);
        chk("rst idle", {o_memory_drive_permit, o_ad_oe, o_rd_valid},
            0);
      end
      p = o_bus_reference_clock;
      c = 0;
      repeat (16) begin
        @(negedge i_clk);
        c += int'(o_bus_reference_clock != p);
        p = o_bus_reference_clock;
      end
      chk("ref clk", c, h ? 8 : 16);
    end
    $display("t_misc done");
  endtask
  initial begin
    {errors, compares, i_req_valid, i_req_write, i_req_kind} = 0;
    {i_quad_refill, i_req_addr, i_req_wdata, i_rd_ready, flt} = 0;
    {i_synchronized_branch_condition, i_direct_branch_condition} = 0;
    {i_floating_point_unit_condition, i_hold_request, dma_done} = 0;
    {i_line_invalidate_request, i_coherent_dma_request, dma_on} = 0;
    {dma_ale, dma_wr, dma_ad, i_half_rate_strap} = 0;
    i_reset = 1;
    repeat (20) @(negedge i_clk);
    i_reset = 0;
    repeat (3) @(negedge i_clk);
    chk("idle", {o_memory_drive_permit, o_hold_acknowledge}, 0);
    t_reads();
    t_writes();
    t_hold();
    t_misc();
    end_sim();
  end
  initial begin
    #400000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
